/* pmcs_top.sv */
// Power monitor conversion sequencer: modes, averaging, results and ready flag
`timescale 1ns/10ps
`default_nettype none
module pmcs_top
  import pmcs_pkg::*;
#(
  parameter int unsigned CLK_PER_US = 1000 / CLK_PERIOD_NS,
  parameter logic [6:0]  DEV_ADDR   = 7'h40
) (
  input  wire logic        i_clk,
  input  wire logic        i_srst,
  input  wire logic        i_link_clk,
  input  wire logic        i_scl,
  input  wire logic        i_sda,
  output logic             o_sda_oe,
  output logic             o_sda_out,
  output logic             o_sense_enable,
  output logic             o_adc_start,
  output logic             o_adc_bus_sel,
  input  wire logic [15:0] i_adc_data,
  output logic             o_conversion_ready_flag
);
  // ---------------------------------------------------------------
  // Elaboration checks
  // ---------------------------------------------------------------
  if (CLK_PER_US < 1 || CLK_PER_US * CT_MAX_US >= 2 ** 24) begin : g_bad_rate
    $error("CLK_PER_US out of range for 24-bit conversion counter");
  end

  localparam logic [23:0] RECOV_LAST = 24'(RECOVERY_CYC - 1);

  function automatic logic [ACC_W-1:0] acc_add(input logic [ACC_W-1:0] acc, input logic [15:0] v,
                                               input logic sgn);
    logic [ACC_W-1:0] ext;
    ext = sgn ? {{(ACC_W-16){v[15]}}, v} : {{(ACC_W-16){1'h0}}, v};
    return acc + ext;
  endfunction

  function automatic logic [15:0] avg_out(input logic [ACC_W-1:0] sum, input logic [3:0] sh);
    logic signed [ACC_W-1:0] s;
    s = $signed(sum) >>> sh;
    return s[15:0];
  endfunction

  // ---------------------------------------------------------------
  // Link and clock crossing
  // ---------------------------------------------------------------
  pmcs_link_if lk ();

  pmcs_i2c_link #(
    .DEV_ADDR (DEV_ADDR)
  ) u_link (
    .i_link_clk (i_link_clk),
    .i_srst     (i_srst),
    .i_scl      (i_scl),
    .i_sda      (i_sda),
    .o_sda_oe   (o_sda_oe),
    .lk         (lk.link)
  );

  logic wr_s1_reg, wr_s2_reg, wr_prev_reg;
  logic rd_s1_reg, rd_s2_reg, rd_prev_reg;
  logic wr_ev, rd_ev;

  always_ff @(posedge i_clk) begin
    wr_s1_reg   <= lk.wr_tgl;
    wr_s2_reg   <= wr_s1_reg;
    wr_prev_reg <= wr_s2_reg;
    rd_s1_reg   <= lk.rd_tgl;
    rd_s2_reg   <= rd_s1_reg;
    rd_prev_reg <= rd_s2_reg;
  end

  assign wr_ev = wr_s2_reg ^ wr_prev_reg;
  assign rd_ev = rd_s2_reg ^ rd_prev_reg;

  // ---------------------------------------------------------------
  // Registers and decode
  // ---------------------------------------------------------------
  logic [15:0]      setup_reg, scale_reg, limit_reg, mask_reg;
  logic [15:0]      shunt_out_reg, bus_out_reg, cur_out_reg, pwr_out_reg;
  logic [15:0]      last_sh_reg, last_bus_reg, rd_data_reg, rd_mux;
  logic             conversion_ready_flag_reg, rd_ack_reg;
  logic [ACC_W-1:0] acc_sh_reg, acc_bus_reg, acc_cur_reg, acc_pwr_reg;
  logic [ACC_W-1:0] tot_sh, tot_bus, tot_cur, tot_pwr;
  logic [10:0]      sample_cnt_reg, avg_last;
  logic [23:0]      conv_cnt_reg, ct_last;
  pmcs_seq_t        state_reg, first_st;
  logic [2:0]       mode, new_mode, ct_sel;
  logic [3:0]       avg_sh;
  logic             setup_wr, converting, conv_end, seq_end, avg_done;
  logic [15:0]      sh_new, bus_new, cur_new, pwr_new;
  logic signed [32:0] cur_prod, pwr_prod;

  assign setup_wr   = wr_ev && (lk.wr_ptr == REG_SETUP);
  assign new_mode   = lk.wr_data[MODE_LSB +: 3];
  assign mode       = setup_reg[MODE_LSB +: 3];
  assign first_st   = mode[0] ? S_SHUNT : S_BUS;
  assign avg_sh     = pmcs_avg_log2(setup_reg[AVG_LSB +: 3]);
  assign avg_last   = 11'((32'h1 << avg_sh) - 32'h1);
  assign converting = (state_reg == S_SHUNT) || (state_reg == S_BUS);
  assign ct_sel     = (state_reg == S_BUS) ? setup_reg[BCT_LSB +: 3] : setup_reg[SCT_LSB +: 3];
  assign ct_last    = 24'(pmcs_ct_us(ct_sel) * CLK_PER_US - 1);
  // A setup write takes priority so a stale sample never lands after it
  assign conv_end   = converting && (conv_cnt_reg == ct_last) && !setup_wr;
  assign seq_end    = conv_end && ((state_reg == S_BUS) || !mode[1]);
  assign avg_done   = seq_end && (sample_cnt_reg == avg_last);

  // Math is combinational on the capture cycle, so it costs no conversion time
  assign sh_new   = (state_reg == S_SHUNT) ? i_adc_data : last_sh_reg;
  assign bus_new  = (state_reg == S_BUS) ? i_adc_data : last_bus_reg; // Raw code, 1.25 mV steps
  assign cur_prod = $signed(sh_new) * $signed({1'h0, scale_reg});
  assign cur_new  = cur_prod[CUR_SHIFT +: 16];
  assign pwr_prod = $signed(cur_new) * $signed({1'h0, bus_new});
  assign pwr_new  = pwr_prod[PWR_SHIFT +: 16];
  assign tot_sh   = acc_add(acc_sh_reg, sh_new, 1'h1);
  assign tot_bus  = acc_add(acc_bus_reg, bus_new, 1'h0);
  assign tot_cur  = acc_add(acc_cur_reg, cur_new, 1'h1);
  assign tot_pwr  = acc_add(acc_pwr_reg, pwr_new, 1'h1);

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      setup_reg <= SETUP_RESET;
      scale_reg <= 16'h0000;
      limit_reg <= 16'h0000;
      mask_reg  <= 16'h0000;
    end else if (wr_ev) begin
      case (lk.wr_ptr)
        REG_SETUP: setup_reg <= lk.wr_data; // Accepted in power-down too
        REG_SCALE: scale_reg <= lk.wr_data;
        REG_MASK:  mask_reg  <= lk.wr_data & MASK_WR_KEEP;
        REG_LIMIT: limit_reg <= lk.wr_data;
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Conversion sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      state_reg      <= S_RECOV;
      conv_cnt_reg   <= 24'h000000;
      sample_cnt_reg <= 11'h000;
    end else if (setup_wr) begin
      conv_cnt_reg   <= 24'h000000;
      sample_cnt_reg <= 11'h000;
      if (pmcs_is_pd(new_mode)) begin
        state_reg <= S_PDOWN;
      end else if (state_reg == S_PDOWN || state_reg == S_RECOV) begin
        state_reg <= S_RECOV;
      end else begin
        state_reg <= new_mode[0] ? S_SHUNT : S_BUS; // Every write retriggers
      end
    end else begin
      case (state_reg)
        S_RECOV: begin
          if (conv_cnt_reg == RECOV_LAST) begin
            conv_cnt_reg <= 24'h000000;
            state_reg    <= first_st;
          end else begin
            conv_cnt_reg <= conv_cnt_reg + 24'h000001;
          end
        end
        S_SHUNT, S_BUS: begin
          if (!conv_end) begin
            conv_cnt_reg <= conv_cnt_reg + 24'h000001;
          end else begin
            conv_cnt_reg <= 24'h000000;
            if (!seq_end) begin
              state_reg <= S_BUS; // Shunt then bus
            end else begin
              sample_cnt_reg <= avg_done ? 11'h000 : sample_cnt_reg + 11'h001;
              if (avg_done && !mode[2]) begin
                state_reg <= S_IDLE; // Single shot ends here
              end else begin
                state_reg <= first_st;
              end
            end
          end
        end
        S_IDLE, S_PDOWN: ;
        default: state_reg <= S_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Samples, accumulators and output registers
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      last_sh_reg  <= 16'h0000;
      last_bus_reg <= 16'h0000;
    end else if (conv_end) begin
      last_sh_reg  <= sh_new;
      last_bus_reg <= bus_new;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst || setup_wr || avg_done) begin
      acc_sh_reg  <= '0;
      acc_bus_reg <= '0;
      acc_cur_reg <= '0;
      acc_pwr_reg <= '0;
    end else if (seq_end) begin
      acc_sh_reg  <= tot_sh;
      acc_bus_reg <= tot_bus;
      acc_cur_reg <= tot_cur;
      acc_pwr_reg <= tot_pwr;
    end
  end

  // Outputs change only on a finished average; reads never touch them
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      shunt_out_reg <= 16'h0000;
      bus_out_reg   <= 16'h0000;
      cur_out_reg   <= 16'h0000;
      pwr_out_reg   <= 16'h0000;
    end else if (avg_done) begin
      shunt_out_reg <= avg_out(tot_sh, avg_sh);
      bus_out_reg   <= avg_out(tot_bus, avg_sh);
      cur_out_reg   <= avg_out(tot_cur, avg_sh);
      pwr_out_reg   <= avg_out(tot_pwr, avg_sh);
    end
  end

  // ---------------------------------------------------------------
  // Ready flag and read answers
  // ---------------------------------------------------------------
  // Set wins over the mask-read clear in the same cycle; a setup write blocks the set
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      conversion_ready_flag_reg <= 1'h0;
    end else if (avg_done) begin
      conversion_ready_flag_reg <= 1'h1;
    end else if (setup_wr && !pmcs_is_pd(new_mode)) begin
      conversion_ready_flag_reg <= 1'h0;
    end else if (rd_ev && lk.rd_ptr == REG_MASK) begin
      conversion_ready_flag_reg <= 1'h0;
    end
  end

  always_comb begin
    case (lk.rd_ptr)
      REG_SETUP:   rd_mux = setup_reg;
      REG_SHUNT:   rd_mux = shunt_out_reg;
      REG_BUS:     rd_mux = bus_out_reg;
      REG_POWER:   rd_mux = pwr_out_reg;
      REG_CURRENT: rd_mux = cur_out_reg;
      REG_SCALE:   rd_mux = scale_reg;
      REG_MASK: begin
        rd_mux           = mask_reg;
        rd_mux[CONVERSION_READY_FLAG_BIT] = conversion_ready_flag_reg;
      end
      REG_LIMIT:   rd_mux = limit_reg;
      default:     rd_mux = 16'h0000;
    endcase
  end

  // Snapshot taken before the flag clears, so the host sees the set value
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      rd_data_reg <= 16'h0000;
      rd_ack_reg  <= 1'h0;
    end else if (rd_ev) begin
      rd_data_reg <= rd_mux;
      rd_ack_reg  <= ~rd_ack_reg;
    end
  end

  assign lk.rd_data              = rd_data_reg;
  assign lk.rd_ack_tgl           = rd_ack_reg;
  assign o_sda_out               = 1'h0;
  assign o_sense_enable          = (state_reg != S_PDOWN);
  assign o_adc_start             = converting && (conv_cnt_reg == 24'h000000);
  assign o_adc_bus_sel           = (state_reg == S_BUS);
  assign o_conversion_ready_flag = conversion_ready_flag_reg;
endmodule // pmcs_top
`default_nettype wire

/* pmcs_pkg.sv */
// Shared constants, types and helpers for the power monitor conversion sequencer
`default_nettype none
package pmcs_pkg;
  // ---------------------------------------------------------------
  // Register map (pointer values on the two-wire port)
  // ---------------------------------------------------------------
  localparam logic [7:0]  REG_SETUP   = 8'h00;
  localparam logic [7:0]  REG_SHUNT   = 8'h01;
  localparam logic [7:0]  REG_BUS     = 8'h02;
  localparam logic [7:0]  REG_POWER   = 8'h03;
  localparam logic [7:0]  REG_CURRENT = 8'h04;
  localparam logic [7:0]  REG_SCALE   = 8'h05;
  localparam logic [7:0]  REG_MASK    = 8'h06;
  localparam logic [7:0]  REG_LIMIT   = 8'h07;
  // ---------------------------------------------------------------
  // Field layout and reset values
  // ---------------------------------------------------------------
  localparam logic [15:0] SETUP_RESET  = 16'h4127;
  localparam int          MODE_LSB     = 0;
  localparam int          SCT_LSB      = 3;
  localparam int          BCT_LSB      = 6;
  localparam int          AVG_LSB      = 9;
  localparam int          CONVERSION_READY_FLAG_BIT     = 3;
  localparam logic [15:0] MASK_WR_KEEP = 16'hFC03;
  localparam logic [2:0]  MODE_PD_A    = 3'h0;
  localparam logic [2:0]  MODE_PD_B    = 3'h4;
  // ---------------------------------------------------------------
  // Timing and arithmetic
  // ---------------------------------------------------------------
  localparam int          CLK_PERIOD_NS     = 20;
  localparam int          RECOVERY_US       = 40;
  localparam int          RECOVERY_CYC      = (RECOVERY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          BUS_LSB_UV        = 1250;
  localparam int          BUS_FULL_SCALE_MV = 40960;
  localparam int          CUR_SHIFT         = 11;
  localparam int          PWR_SHIFT         = 12;
  localparam int          ACC_W             = 27;
  localparam int          CT_MAX_US         = 8244;

  typedef enum logic [2:0] {
    S_IDLE  = 3'h0,
    S_RECOV = 3'h1,
    S_SHUNT = 3'h3,
    S_BUS   = 3'h2,
    S_PDOWN = 3'h6
  } pmcs_seq_t;

  typedef enum logic [2:0] {
    L_IDLE = 3'h0,
    L_RX   = 3'h1,
    L_ACK  = 3'h3,
    L_TX   = 3'h2,
    L_MACK = 3'h6
  } pmcs_link_state_t;

  function automatic int unsigned pmcs_ct_us(input logic [2:0] sel);
    case (sel)
      3'h0:    return 140;
      3'h1:    return 204;
      3'h2:    return 332;
      3'h3:    return 588;
      3'h4:    return 1100;
      3'h5:    return 2116;
      3'h6:    return 4156;
      default: return 8244;
    endcase
  endfunction

  function automatic logic [3:0] pmcs_avg_log2(input logic [2:0] sel);
    case (sel)
      3'h0:    return 4'h0;
      3'h1:    return 4'h2;
      3'h2:    return 4'h4;
      3'h3:    return 4'h6;
      3'h4:    return 4'h7;
      3'h5:    return 4'h8;
      3'h6:    return 4'h9;
      default: return 4'hA;
    endcase
  endfunction

  function automatic logic pmcs_is_pd(input logic [2:0] m);
    return (m == MODE_PD_A) || (m == MODE_PD_B);
  endfunction
endpackage
`default_nettype wire

/* pmcs_link_if.sv */
// Interface carrying register traffic between the link and core clock domains
`timescale 1ns/10ps
`default_nettype none
interface pmcs_link_if;
  logic        wr_tgl;
  logic [7:0]  wr_ptr;
  logic [15:0] wr_data;
  logic        rd_tgl;
  logic [7:0]  rd_ptr;
  logic        rd_ack_tgl;
  logic [15:0] rd_data;

  modport link (output wr_tgl, wr_ptr, wr_data, rd_tgl, rd_ptr, input rd_ack_tgl, rd_data);
  modport core (input wr_tgl, wr_ptr, wr_data, rd_tgl, rd_ptr, output rd_ack_tgl, rd_data);
endinterface
`default_nettype wire

/* pmcs_i2c_link.sv */
// Two-wire register port slave running in the link clock domain
`timescale 1ns/10ps
`default_nettype none
module pmcs_i2c_link
  import pmcs_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = 7'h40
) (
  input  wire logic      i_link_clk,
  input  wire logic      i_srst,
  input  wire logic      i_scl,
  input  wire logic      i_sda,
  output logic           o_sda_oe,
  pmcs_link_if.link      lk
);
  // ---------------------------------------------------------------
  // Synchronisers
  // ---------------------------------------------------------------
  logic             rst_s1_reg, rst_reg;
  logic             scl_s1_reg, scl_reg, scl_prev_reg;
  logic             sda_s1_reg, sda_reg, sda_prev_reg;
  logic             ack_s1_reg, ack_reg, ack_prev_reg;
  pmcs_link_state_t st_reg;
  logic [3:0]       bit_cnt_reg;
  logic [2:0]       byte_idx_reg;
  logic [7:0]       sh_reg, ptr_reg, hi_reg;
  logic [15:0]      tx_word_reg, wr_data_reg;
  logic             rw_reg, tx_lo_reg, mack_reg, oe_reg, wr_tgl_reg, rd_tgl_reg;
  logic             start_w, stop_w, rise_w, fall_w;
  logic [7:0]       tx_cur;

  always_ff @(posedge i_link_clk) begin
    rst_s1_reg   <= i_srst;
    rst_reg      <= rst_s1_reg;
    scl_s1_reg   <= i_scl;
    scl_reg      <= scl_s1_reg;
    scl_prev_reg <= scl_reg;
    sda_s1_reg   <= i_sda;
    sda_reg      <= sda_s1_reg;
    sda_prev_reg <= sda_reg;
    ack_s1_reg   <= lk.rd_ack_tgl;
    ack_reg      <= ack_s1_reg;
    ack_prev_reg <= ack_reg;
  end

  assign start_w = scl_reg & scl_prev_reg & sda_prev_reg & ~sda_reg;
  assign stop_w  = scl_reg & scl_prev_reg & ~sda_prev_reg & sda_reg;
  assign rise_w  = scl_reg & ~scl_prev_reg;
  assign fall_w  = ~scl_reg & scl_prev_reg;
  assign tx_cur  = tx_lo_reg ? tx_word_reg[7:0] : tx_word_reg[15:8];

  // Core answer is captured whenever its toggle moves; it always lands long before SCL falls
  always_ff @(posedge i_link_clk) begin
    if (rst_reg) begin
      tx_word_reg <= 16'h0000;
    end else if (ack_reg ^ ack_prev_reg) begin
      tx_word_reg <= lk.rd_data;
    end
  end

  // ---------------------------------------------------------------
  // Byte engine: address, pointer, high byte, low byte
  // ---------------------------------------------------------------
  always_ff @(posedge i_link_clk) begin
    if (rst_reg) begin
      st_reg       <= L_IDLE;
      bit_cnt_reg  <= 4'h0;
      byte_idx_reg <= 3'h0;
      sh_reg       <= 8'h00;
      ptr_reg      <= 8'h00;
      hi_reg       <= 8'h00;
      wr_data_reg  <= 16'h0000;
      rw_reg       <= 1'h0;
      tx_lo_reg    <= 1'h0;
      mack_reg     <= 1'h0;
      oe_reg       <= 1'h0;
      wr_tgl_reg   <= 1'h0;
      rd_tgl_reg   <= 1'h0;
    end else if (start_w) begin
      st_reg       <= L_RX;
      bit_cnt_reg  <= 4'h0;
      byte_idx_reg <= 3'h0;
      oe_reg       <= 1'h0;
    end else if (stop_w) begin
      st_reg <= L_IDLE;
      oe_reg <= 1'h0;
    end else begin
      case (st_reg)
        L_RX: begin
          if (rise_w) begin
            sh_reg      <= {sh_reg[6:0], sda_reg};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end else if (fall_w && bit_cnt_reg == 4'h8) begin
            bit_cnt_reg <= 4'h0;
            if (byte_idx_reg == 3'h0 && sh_reg[7:1] != DEV_ADDR) begin
              st_reg <= L_IDLE;
            end else begin
              st_reg <= L_ACK;
              oe_reg <= 1'h1;
              case (byte_idx_reg)
                3'h0: begin
                  rw_reg    <= sh_reg[0];
                  tx_lo_reg <= 1'h0;
                  if (sh_reg[0]) begin
                    rd_tgl_reg <= ~rd_tgl_reg; // Ask core for current pointer word
                  end
                end
                3'h1: ptr_reg <= sh_reg;
                3'h2: hi_reg <= sh_reg;
                3'h3: begin
                  wr_data_reg <= {hi_reg, sh_reg};
                  wr_tgl_reg  <= ~wr_tgl_reg;
                end
                default: ;
              endcase
            end
          end
        end
        L_ACK: begin
          if (fall_w) begin
            byte_idx_reg <= (byte_idx_reg == 3'h4) ? 3'h4 : byte_idx_reg + 3'h1;
            if (rw_reg) begin
              st_reg <= L_TX;
              oe_reg <= ~tx_cur[7];
            end else begin
              st_reg <= L_RX;
              oe_reg <= 1'h0;
            end
          end
        end
        L_TX: begin
          if (fall_w) begin
            if (bit_cnt_reg == 4'h7) begin
              bit_cnt_reg <= 4'h0;
              st_reg      <= L_MACK;
              oe_reg      <= 1'h0;
            end else begin
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
              oe_reg      <= ~tx_cur[3'(4'h6 - bit_cnt_reg)];
            end
          end
        end
        L_MACK: begin
          if (rise_w) begin
            if (sda_reg) begin
              st_reg <= L_IDLE;
            end else begin
              tx_lo_reg <= ~tx_lo_reg;
              mack_reg  <= 1'h1;
            end
          end else if (fall_w && mack_reg) begin
            mack_reg <= 1'h0;
            st_reg   <= L_TX;
            oe_reg   <= ~tx_cur[7];
          end
        end
        L_IDLE: ;
        default: st_reg <= L_IDLE;
      endcase
    end
  end

  assign o_sda_oe   = oe_reg;
  assign lk.wr_tgl  = wr_tgl_reg;
  assign lk.wr_ptr  = ptr_reg;
  assign lk.wr_data = wr_data_reg;
  assign lk.rd_tgl  = rd_tgl_reg;
  assign lk.rd_ptr  = ptr_reg;
endmodule // pmcs_i2c_link
`default_nettype wire

/* pmcs_sva.sv */
// Port checker for the power monitor conversion sequencer
`timescale 1ns/10ps
`default_nettype none
module pmcs_sva (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic o_sda_out,
  input wire logic o_sense_enable,
  input wire logic o_adc_start,
  input wire logic o_adc_bus_sel,
  input wire logic o_conversion_ready_flag
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_srst);
  sda_zero_a: assert property (o_sda_out == 1'b0) else $error("sda drive value not zero");
  start_gap_a: assert property (o_adc_start |=> !o_adc_start [*8]) else $error("start too close");
  pd_nostart_a: assert property (!o_sense_enable |-> !o_adc_start) else $error("start in power-down");
  pd_nobus_a: assert property (!o_sense_enable |-> !o_adc_bus_sel) else $error("bus select in power-down");
  flag_rise_a: assert property ($rose(o_conversion_ready_flag) |-> !$past(o_adc_start))
    else $error("ready set at conversion start");
  recov_gap_a: assert property ($rose(o_sense_enable) |=> !o_adc_start [*8]) else $error("no recovery");
  bus_start_a: assert property ($rose(o_adc_bus_sel) |-> o_adc_start) else $error("bus without start");
  pd_noflag_a: assert property (!o_sense_enable |-> !$rose(o_conversion_ready_flag))
    else $error("result in power-down");
  ready_c: cover property ($rose(o_conversion_ready_flag));
  pdown_c: cover property ($fell(o_sense_enable));
  bus_c: cover property ($rose(o_adc_bus_sel));
endmodule // pmcs_sva
bind pmcs_top pmcs_sva pmcs_sva_inst (.i_clk(i_clk), .i_srst(i_srst), .o_sda_out(o_sda_out),
  .o_sense_enable(o_sense_enable), .o_adc_start(o_adc_start), .o_adc_bus_sel(o_adc_bus_sel),
  .o_conversion_ready_flag(o_conversion_ready_flag));
`default_nettype wire

/* pmcs_host.sv */
// Two-wire bus host model issuing register transactions
`timescale 1ns/10ps
`default_nettype none
module pmcs_host (
  input  wire logic i_clk,
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_sdm
);
  logic nak = 1'b0;
  initial begin
    o_scl = 1'b1;
    o_sdm = 1'b1;
  end
  // Quarter bit of 25 clocks keeps SCL low far beyond the link's need
  task automatic q;
    repeat (25) @(posedge i_clk);
    #1;
  endtask
  task automatic bit_io(input logic b, output logic r);
    o_sdm = b;
    q;
    o_scl = 1'b1;
    q;
    r = i_sda;
    q;
    o_scl = 1'b0;
    q;
  endtask
  task automatic start;
    o_sdm = 1'b1;
    o_scl = 1'b1;
    q;
    o_sdm = 1'b0;
    q;
    o_scl = 1'b0;
    q;
  endtask
  task automatic stop;
    o_sdm = 1'b0;
    q;
    o_scl = 1'b1;
    q;
    o_sdm = 1'b1;
    q;
  endtask
  task automatic byte_io(input logic [7:0] b, input logic m, input logic w, output logic [7:0] r);
    logic a;
    for (int i = 7; i >= 0; i--) bit_io(b[i], r[i]);
    bit_io(m, a);
    if (w) nak |= a;
  endtask
  task automatic wr(input logic [7:0] p, input logic [15:0] d);
    logic [7:0] r;
    start;
    byte_io(8'h80, 1'b1, 1'b1, r);
    byte_io(p, 1'b1, 1'b1, r);
    byte_io(d[15:8], 1'b1, 1'b1, r);
    byte_io(d[7:0], 1'b1, 1'b1, r);
    stop;
  endtask
  task automatic rd(input logic [7:0] p, output logic [15:0] d);
    logic [7:0] r;
    start;
    byte_io(8'h80, 1'b1, 1'b1, r);
    byte_io(p, 1'b1, 1'b1, r);
    stop;
    start;
    byte_io(8'h81, 1'b1, 1'b1, r);
    byte_io(8'hFF, 1'b0, 1'b0, d[15:8]);
    byte_io(8'hFF, 1'b1, 1'b0, d[7:0]);
    stop;
  endtask
endmodule // pmcs_host
`default_nettype wire

/* pmcs_tb_top.sv */
// Testbench for the power monitor conversion sequencer
`timescale 1ns/10ps
`default_nettype none
module pmcs_tb_top;
  import pmcs_pkg::*;
  logic        i_clk = 1'b0;
  logic        i_srst = 1'b1;
  logic        i_link_clk = 1'b0;
  logic        scl, sdm;
  logic [15:0] rv;
  int          error_cnt = 0;
  int          total_checks = 0;
  wire logic   sda_oe, sense, start, bsel, flag;
  wire logic   sda = sdm & ~sda_oe;
  wire logic [15:0] adc = bsel ? 16'h1000 : 16'h0100;
  always #10 i_clk = ~i_clk;
  initial begin
    #3;
    forever #32 i_link_clk = ~i_link_clk;
  end
  pmcs_top #(.CLK_PER_US(1)) pmcs_top_inst (.i_clk(i_clk), .i_srst(i_srst), .i_link_clk(i_link_clk),
    .i_scl(scl), .i_sda(sda), .o_sda_oe(sda_oe), .o_sda_out(), .o_sense_enable(sense), .o_adc_start(start),
    .o_adc_bus_sel(bsel), .i_adc_data(adc), .o_conversion_ready_flag(flag));
  pmcs_host pmcs_host_inst (.i_clk(i_clk), .i_sda(sda), .o_scl(scl), .o_sdm(sdm));
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    total_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic t_cont;
    cyc(4500);
    chk("ready", 16'(flag), 16'h0001);
  endtask
  task automatic t_single;
    pmcs_host_inst.wr(REG_SCALE, 16'h0800);
    pmcs_host_inst.wr(REG_SETUP, 16'h0003);
    cyc(400);
    pmcs_host_inst.rd(REG_MASK, rv);
    chk("ready bit", 16'(rv[CONVERSION_READY_FLAG_BIT]), 16'h0001);
    chk("ready cleared", 16'(flag), 16'h0000);
    pmcs_host_inst.rd(REG_SHUNT, rv);
    chk("shunt", rv, 16'h0100);
    pmcs_host_inst.rd(REG_BUS, rv);
    chk("bus", rv, 16'h1000);
    pmcs_host_inst.rd(REG_CURRENT, rv);
    chk("current", rv, 16'h0100);
    pmcs_host_inst.rd(REG_POWER, rv);
    chk("power", rv, 16'h0100);
    chk("stopped", 16'(flag), 16'h0000);
  endtask
  task automatic t_retrig;
    pmcs_host_inst.wr(REG_SETUP, 16'h0003);
    cyc(400);
    chk("retrigger", 16'(flag), 16'h0001);
  endtask
  task automatic t_pd;
    pmcs_host_inst.wr(REG_SETUP, 16'h0000);
    chk("pd keeps ready", 16'(flag), 16'h0001);
    chk("sense off", 16'(sense), 16'h0000);
    pmcs_host_inst.rd(REG_SETUP, rv);
    chk("pd readback", rv, 16'h0000);
    cyc(3000);
    chk("pd holds", 16'(sense), 16'h0000);
    pmcs_host_inst.wr(REG_SETUP, 16'h01FF);
    chk("write clears", 16'(flag), 16'h0000);
    cyc(3000); // Past the 2000-clock recovery but inside the first 8244-clock shunt conversion
    chk("slow pending", {14'h0, sense, flag}, 16'h0002);
  endtask
  // Long bus time exposes any stray bus conversion in shunt-only mode
  task automatic t_modes;
    pmcs_host_inst.wr(REG_SETUP, 16'h03C1);
    cyc(200);
    chk("avg pending", 16'(flag), 16'h0000);
    cyc(400);
    chk("shunt only avg", 16'(flag), 16'h0001);
    pmcs_host_inst.wr(REG_SETUP, 16'h003A);
    cyc(400);
    chk("bus only", 16'(flag), 16'h0001);
    pmcs_host_inst.wr(REG_SETUP, 16'h01F1);
    pmcs_host_inst.rd(REG_BUS, rv);
    chk("bus kept", rv, 16'h1000);
    chk("read no disturb", 16'(flag), 16'h0001);
  endtask
  initial begin
    cyc(16);
    i_srst = 1'b0;
    t_cont;
    t_single;
    t_retrig;
    t_pd;
    t_modes;
    chk("ack", 16'(pmcs_host_inst.nak), 16'h0000);
    complete_run;
  end
  initial begin
    // About 76k clocks of tests; limit kept under 100k clocks
    #1800000;
    error_cnt++;
    complete_run;
  end
endmodule // pmcs_tb_top
`default_nettype wire
